// *** hdl/flash_table_pkg.sv ***
package flash_table_pkg;

   // ----------------------------------------
   // register select codes on the special function port
   // ----------------------------------------
   localparam logic [2:0] SEL_CONTROL = 3'h0;
   localparam logic [2:0] SEL_UNLOCK = 3'h1;
   localparam logic [2:0] SEL_LATCH = 3'h2;
   localparam logic [2:0] SEL_PTR_UPPER = 3'h3;
   localparam logic [2:0] SEL_PTR_HIGH = 3'h4;
   localparam logic [2:0] SEL_PTR_LOW = 3'h5;

   // ----------------------------------------
   // memory_access_control field positions
   // ----------------------------------------
   localparam int BIT_PROG_SEL = 7;
   localparam int BIT_CFG_SEL = 6;
   localparam int BIT_ERASE_EN = 4;
   localparam int BIT_ABORT = 3;
   localparam int BIT_PERMIT = 2;
   localparam int BIT_WR = 1;
   localparam int BIT_RD = 0;

   // ----------------------------------------
   // widths, keys and reset values
   // ----------------------------------------
   localparam int PTR_W = 22;
   localparam int HOLD_N = 8;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [7:0] HOLD_RESET = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int PROG_TIME_US = 2000;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam int TIMER_W = 17;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      TBL_NONE = 2'b00,
      TBL_POSTINC = 2'b01,
      TBL_POSTDEC = 2'b10,
      TBL_PREINC = 2'b11
   } tbl_mode_e;

   typedef enum logic [1:0] {
      SPACE_EEPROM = 2'b00,
      SPACE_PROGRAM = 2'b01,
      SPACE_CONFIG = 2'b10
   } space_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_LONG = 2'b10
   } seq_state_e;

   typedef struct packed {
      logic [2:0] sel;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic req;
      logic write;
      tbl_mode_e mode;
   } tbl_req_s;

   typedef struct packed {
      logic req;
      space_e space;
      logic [PTR_W-1:0] addr;
   } flash_rd_s;

   typedef struct packed {
      logic active;
      logic erase;
      space_e space;
      logic [PTR_W-1:0] addr;
      logic [8*HOLD_N-1:0] data;
   } prog_cmd_s;

endpackage

// *** hdl/prog_timer.sv ***
`timescale 1ns/1ps
module prog_timer
   import flash_table_pkg::*;
#(
   parameter int CYCLES = PROG_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   output logic done
);
   logic [TIMER_W-1:0] cnt_reg;
   logic run_reg;
   logic done_reg;

   // ----------------------------------------
   // countdown
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start) begin
            cnt_reg <= TIMER_W'(CYCLES);
            run_reg <= 1'b1;
         end else if (run_reg) begin
            if (cnt_reg == TIMER_W'(1)) begin
               run_reg <= 1'b0;
               done_reg <= 1'b1;
            end
            cnt_reg <= cnt_reg - TIMER_W'(1);
         end
      end
   end

   assign done = done_reg;

   property p_timer_done;
      @(posedge clk) disable iff (!nrst)
      done |-> $past(run_reg) && ($past(cnt_reg) == TIMER_W'(1));
   endproperty
   a_timer_done: assert property (p_timer_done) else $error("timer ended off count");

endmodule // prog_timer

// *** hdl/program_flash_table_access.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - unlock port stores nothing, reads zero
// - bit 7 picks program flash or eeprom
// - bit 6 picks config space, overriding bit 7
// - bit 4 makes next start an erase
// - writes need write permit; clear at reset
// - abort flag set at start, cleared at end
// - write start set-only, hardware clears it
// - done flag set at end, software clears
// - eight-bit latch carries every byte
// - three bytes form 22-bit byte pointer
// - pointer top bit selects id/config space on table reads
// - four pointer update modes per table op
// - pointer steps leave top bit alone
// - table read uses all 22 pointer bits
// - address lsb picks byte of word
// - table write fills holding reg by ptr[2:0]
// - ptr[21:3] selects the 8-byte block
// - erase row by ptr[21:6], low ignored
// - only whole 64-byte row erase offered
// - core stalls for the timed long cycle
// - holding regs FFh after reset and write
module program_flash_table_access #(
   parameter int PROG_TIME_CYCLES = flash_table_pkg::PROG_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input flash_table_pkg::sfr_req_s sfr,
   output logic [7:0] sfr_rdata,
   input flash_table_pkg::tbl_req_s tbl,
   output logic tbl_ready,
   output logic tbl_done,
   output flash_table_pkg::flash_rd_s flash_rd,
   input wire logic [15:0] flash_rdata,
   input wire logic flash_rvalid,
   output flash_table_pkg::prog_cmd_s prog,
   output logic cpu_stall,
   output logic nvm_done_flag,
   input wire logic nvm_done_clear
);
   import flash_table_pkg::*;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic space_e space_of(input logic cfg, input logic prog_sel);
      // config select overrides the program/eeprom choice
      if (cfg) begin
         return SPACE_CONFIG;
      end
      return prog_sel ? SPACE_PROGRAM : SPACE_EEPROM;
   endfunction

   function automatic logic [PTR_W-1:0] step_ptr(input logic [PTR_W-1:0] p, input logic down);
      logic [PTR_W-2:0] low;
      low = down ? (p[PTR_W-2:0] - 21'h000001) : (p[PTR_W-2:0] + 21'h000001);
      return {p[PTR_W-1], low};
   endfunction

   seq_state_e state_reg;
   seq_state_e state_next;
   logic [PTR_W-1:0] table_pointer_reg;
   logic [7:0] table_data_latch_reg;
   logic [7:0] hold_reg [HOLD_N];
   logic [8*HOLD_N-1:0] hold_flat;
   logic prog_sel_reg, cfg_sel_reg, erase_en_reg, abort_reg, permit_reg, wr_reg, rd_reg;
   logic [1:0] unlock_stage_reg;
   logic read_from_ctl_reg;
   logic [7:0] sfr_rdata_reg;
   logic tbl_ready_reg, tbl_done_reg, stall_reg, nvm_done_reg;
   flash_rd_s flash_rd_reg;
   prog_cmd_s prog_reg;
   logic timer_done;
   logic wr_ctl, wr_start_req, start_ok, start_bad, rd_start, tbl_go, armed;
   logic [PTR_W-1:0] access_addr;
   logic [7:0] read_byte;

   assign wr_ctl = sfr.wr && (sfr.sel == SEL_CONTROL) && (state_reg != ST_LONG);
   assign armed = (unlock_stage_reg == 2'h2);
   assign wr_start_req = wr_ctl && sfr.wdata[BIT_WR] && !wr_reg && (state_reg == ST_IDLE);
   // start needs permit and fresh unlock
   assign start_ok = wr_start_req && armed && permit_reg;
   assign start_bad = wr_start_req && !start_ok;
   assign rd_start = wr_ctl && sfr.wdata[BIT_RD] && !rd_reg && (state_reg == ST_IDLE) && !start_ok;
   // table ops only while idle; the core waits on tbl_ready
   assign tbl_go = tbl.req && tbl_ready_reg && (state_reg == ST_IDLE) && !start_ok && !rd_start;
   assign access_addr = (tbl.mode == TBL_PREINC) ? step_ptr(table_pointer_reg, 1'b0) : table_pointer_reg;
   // lsb picks high or low byte of word
   assign read_byte = flash_rd_reg.addr[0] ? flash_rdata[15:8] : flash_rdata[7:0];

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (start_ok) begin
               state_next = ST_LONG;
            end else if (rd_start || (tbl_go && !tbl.write)) begin
               state_next = ST_READ;
            end
         end
         ST_READ: begin
            if (flash_rvalid) begin
               state_next = ST_IDLE;
            end
         end
         ST_LONG: begin
            if (timer_done) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   prog_timer #(
      .CYCLES(PROG_TIME_CYCLES)
   ) u_timer (
      .clk(clk),
      .nrst(nrst),
      .start(start_ok),
      .done(timer_done)
   );

   // ----------------------------------------
   // table pointer
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         table_pointer_reg <= '0;
      end else if (tbl_go) begin
         // steps touch only low 21 bits
         case (tbl.mode)
            TBL_POSTINC, TBL_PREINC: table_pointer_reg <= step_ptr(table_pointer_reg, 1'b0);
            TBL_POSTDEC: table_pointer_reg <= step_ptr(table_pointer_reg, 1'b1);
            default: table_pointer_reg <= table_pointer_reg;
         endcase
      end else if (sfr.wr && (state_reg != ST_LONG)) begin
         case (sfr.sel)
            SEL_PTR_UPPER: table_pointer_reg[PTR_W-1:16] <= sfr.wdata[5:0];
            SEL_PTR_HIGH: table_pointer_reg[15:8] <= sfr.wdata;
            SEL_PTR_LOW: table_pointer_reg[7:0] <= sfr.wdata;
            default: table_pointer_reg <= table_pointer_reg;
         endcase
      end
   end

   // ----------------------------------------
   // table latch and holding registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         table_data_latch_reg <= BYTE_ZERO;
      end else if ((state_reg == ST_READ) && flash_rvalid) begin
         table_data_latch_reg <= read_byte;
      end else if (sfr.wr && (sfr.sel == SEL_LATCH) && (state_reg != ST_LONG)) begin
         table_data_latch_reg <= sfr.wdata;
      end
   end

   generate
      for (genvar i = 0; i < HOLD_N; i++) begin : g_hold
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               hold_reg[i] <= HOLD_RESET;
            end else if ((state_reg == ST_LONG) && timer_done) begin
               // back to FFh after every long cycle
               hold_reg[i] <= HOLD_RESET;
            end else if (tbl_go && tbl.write && (access_addr[2:0] == 3'(i))) begin
               // low pointer bits pick the holding reg
               hold_reg[i] <= table_data_latch_reg;
            end
         end
         assign hold_flat[8*i +: 8] = hold_reg[i];
      end
   endgenerate

   // ----------------------------------------
   // memory_access_control bits
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prog_sel_reg <= 1'b0;
         cfg_sel_reg <= 1'b0;
         permit_reg <= 1'b0;
      end else if (wr_ctl) begin
         prog_sel_reg <= sfr.wdata[BIT_PROG_SEL];
         cfg_sel_reg <= sfr.wdata[BIT_CFG_SEL];
         permit_reg <= sfr.wdata[BIT_PERMIT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         erase_en_reg <= 1'b0;
      end else if ((state_reg == ST_LONG) && timer_done && prog_reg.erase) begin
         // erase enable drops after the erase
         erase_en_reg <= 1'b0;
      end else if (wr_ctl) begin
         erase_en_reg <= sfr.wdata[BIT_ERASE_EN];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         abort_reg <= 1'b0;
      end else if (start_ok || start_bad) begin
         // set at start and by an improper try
         abort_reg <= 1'b1;
      end else if ((state_reg == ST_LONG) && timer_done) begin
         abort_reg <= 1'b0;
      end else if (wr_ctl) begin
         abort_reg <= sfr.wdata[BIT_ABORT];
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_reg <= 1'b0;
      end else if (start_ok) begin
         wr_reg <= 1'b1;
      end else if ((state_reg == ST_LONG) && timer_done) begin
         wr_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_reg <= 1'b0;
         read_from_ctl_reg <= 1'b0;
      end else if (rd_start) begin
         rd_reg <= 1'b1;
         read_from_ctl_reg <= 1'b1;
      end else if ((state_reg == ST_READ) && flash_rvalid) begin
         rd_reg <= 1'b0;
         read_from_ctl_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // unlock sequence
   // ----------------------------------------
   // any other register write between the keys and the start disarms
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         unlock_stage_reg <= 2'h0;
      end else if (sfr.wr && (sfr.sel == SEL_UNLOCK)) begin
         if (sfr.wdata == UNLOCK_KEY1) begin
            unlock_stage_reg <= 2'h1;
         end else if ((unlock_stage_reg == 2'h1) && (sfr.wdata == UNLOCK_KEY2)) begin
            unlock_stage_reg <= 2'h2;
         end else begin
            unlock_stage_reg <= 2'h0;
         end
      end else if (sfr.wr) begin
         unlock_stage_reg <= 2'h0;
      end
   end

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sfr_rdata_reg <= BYTE_ZERO;
      end else if (sfr.rd) begin
         case (sfr.sel)
            SEL_CONTROL: sfr_rdata_reg <= {prog_sel_reg, cfg_sel_reg, 1'b0, erase_en_reg,
                                           abort_reg, permit_reg, wr_reg, rd_reg};
            SEL_LATCH: sfr_rdata_reg <= table_data_latch_reg;
            SEL_PTR_UPPER: sfr_rdata_reg <= {2'b00, table_pointer_reg[PTR_W-1:16]};
            SEL_PTR_HIGH: sfr_rdata_reg <= table_pointer_reg[15:8];
            SEL_PTR_LOW: sfr_rdata_reg <= table_pointer_reg[7:0];
            default: sfr_rdata_reg <= BYTE_ZERO;
         endcase
      end
   end

   // ----------------------------------------
   // flash read request
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flash_rd_reg <= '0;
      end else begin
         flash_rd_reg.req <= 1'b0;
         if (rd_start) begin
            flash_rd_reg.req <= 1'b1;
            flash_rd_reg.space <= space_of(cfg_sel_reg, prog_sel_reg);
            flash_rd_reg.addr <= table_pointer_reg;
         end else if (tbl_go && !tbl.write) begin
            // full 22-bit byte address goes out
            // top pointer bit reaches id/config space
            flash_rd_reg.req <= 1'b1;
            flash_rd_reg.space <= access_addr[PTR_W-1] ? SPACE_CONFIG : SPACE_PROGRAM;
            flash_rd_reg.addr <= access_addr;
         end
      end
   end

   // ----------------------------------------
   // long cycle command
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         prog_reg <= '0;
      end else if (start_ok) begin
         prog_reg.active <= 1'b1;
         prog_reg.erase <= erase_en_reg;
         prog_reg.space <= space_of(cfg_sel_reg, prog_sel_reg);
         prog_reg.data <= hold_flat;
         prog_reg.addr <= erase_en_reg ? {table_pointer_reg[PTR_W-1:6], 6'h00}
                                       : {table_pointer_reg[PTR_W-1:3], 3'h0};
      end else if ((state_reg == ST_LONG) && timer_done) begin
         prog_reg.active <= 1'b0;
      end
   end

   // ----------------------------------------
   // core handshake and done flag
   // ----------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tbl_ready_reg <= 1'b0;
         tbl_done_reg <= 1'b0;
         stall_reg <= 1'b0;
      end else begin
         tbl_ready_reg <= (state_next == ST_IDLE);
         // core halts through the long cycle
         stall_reg <= (state_next == ST_LONG);
         tbl_done_reg <= (tbl_go && tbl.write) ||
                         ((state_reg == ST_READ) && flash_rvalid && !read_from_ctl_reg);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         nvm_done_reg <= 1'b0;
      end else if ((state_reg == ST_LONG) && timer_done) begin
         // set wins over a same-cycle clear
         nvm_done_reg <= 1'b1;
      end else if (nvm_done_clear) begin
         nvm_done_reg <= 1'b0;
      end
   end

   assign sfr_rdata = sfr_rdata_reg;
   assign tbl_ready = tbl_ready_reg;
   assign tbl_done = tbl_done_reg;
   assign flash_rd = flash_rd_reg;
   assign prog = prog_reg;
   assign cpu_stall = stall_reg;
   assign nvm_done_flag = nvm_done_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_long_start;
      $rose(prog_reg.active);
   endsequence

   sequence s_long_end;
      $fell(prog_reg.active);
   endsequence

   property p_unlock_zero;
      @(posedge clk) disable iff (!nrst)
      sfr.rd && (sfr.sel == SEL_UNLOCK) |=> (sfr_rdata_reg == BYTE_ZERO);
   endproperty
   a_unlock_zero: assert property (p_unlock_zero) else $error("unlock port read nonzero");

   property p_space;
      @(posedge clk) disable iff (!nrst)
      s_long_start |-> prog_reg.space == $past(space_of(cfg_sel_reg, prog_sel_reg));
   endproperty
   a_space: assert property (p_space) else $error("long cycle in wrong space");

   property p_erase_clear;
      @(posedge clk) disable iff (!nrst)
      s_long_end ##0 prog_reg.erase |-> !erase_en_reg;
   endproperty
   a_erase_clear: assert property (p_erase_clear) else $error("erase enable kept after erase");

   property p_permit;
      @(posedge clk) disable iff (!nrst)
      s_long_start |-> $past(permit_reg) && $past(armed);
   endproperty
   a_permit: assert property (p_permit) else $error("long cycle without permit or unlock");

   property p_start_flags;
      @(posedge clk) disable iff (!nrst)
      s_long_start |-> abort_reg && wr_reg && cpu_stall;
   endproperty
   a_start_flags: assert property (p_start_flags) else $error("start flags missing");

   property p_end_flags;
      @(posedge clk) disable iff (!nrst)
      s_long_end |-> !abort_reg && !wr_reg && nvm_done_reg && !cpu_stall && (hold_flat == '1);
   endproperty
   a_end_flags: assert property (p_end_flags) else $error("end of long cycle wrong");

   property p_stall;
      @(posedge clk) disable iff (!nrst)
      prog_reg.active |-> cpu_stall;
   endproperty
   a_stall: assert property (p_stall) else $error("core not stalled in long cycle");

   property p_ptr_top;
      @(posedge clk) disable iff (!nrst)
      tbl_go |=> table_pointer_reg[PTR_W-1] == $past(table_pointer_reg[PTR_W-1]);
   endproperty
   a_ptr_top: assert property (p_ptr_top) else $error("pointer top bit changed by step");

   property p_hold_idx;
      @(posedge clk) disable iff (!nrst)
      tbl_go && tbl.write && (tbl.mode == TBL_NONE)
         |=> hold_reg[$past(table_pointer_reg[2:0])] == $past(table_data_latch_reg);
   endproperty
   a_hold_idx: assert property (p_hold_idx) else $error("holding reg not written");

   property p_erase_addr;
      @(posedge clk) disable iff (!nrst)
      s_long_start ##0 prog_reg.erase |-> (prog_reg.addr[5:0] == 6'h00);
   endproperty
   a_erase_addr: assert property (p_erase_addr) else $error("erase row not aligned");

   property p_ignore;
      @(posedge clk) disable iff (!nrst)
      start_bad |=> !prog_reg.active && abort_reg && !wr_reg;
   endproperty
   a_ignore: assert property (p_ignore) else $error("improper start not ignored");

endmodule // program_flash_table_access

// *** bench/flash_model.sv ***
`timescale 1ns/1ps
module flash_model
   import flash_table_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input flash_table_pkg::flash_rd_s rd,
   output logic [15:0] rdata,
   output logic rvalid
);
   import flash_table_pkg::*;
   int wait_n;
   // word of two bytes
   // random latency; data bus toggles when no word is valid
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_n <= 0;
         rvalid <= 1'b0;
         rdata <= 16'h0000;
      end else begin
         rvalid <= (wait_n == 1);
         rdata <= (wait_n == 1) ? {rd.addr[15:8] ^ {6'h00, rd.space}, rd.addr[7:0]} : ~rdata;
         if (rd.req) wait_n <= 1 + $urandom_range(2);
         else if (wait_n != 0) wait_n <= wait_n - 1;
      end
   end
endmodule // flash_model

// *** bench/program_flash_table_access_bench.sv ***
`timescale 1ns/1ps
module program_flash_table_access_bench;
   import flash_table_pkg::*;
   localparam int PT = 20;
   logic clk, nrst, tbl_ready, tbl_done, flash_rvalid, cpu_stall, nvm_done_flag, nvm_done_clear;
   logic [7:0] sfr_rdata;
   logic [15:0] flash_rdata;
   sfr_req_s sfr;
   tbl_req_s tbl;
   flash_rd_s flash_rd;
   prog_cmd_s prog;
   int miscompares, checks_done;
   logic [21:0] ptr, p, a;
   logic [63:0] hold;
   logic [7:0] d;
   tbl_mode_e m;
   program_flash_table_access #(.PROG_TIME_CYCLES(PT)) dut (.clk(clk), .nrst(nrst), .sfr(sfr),
      .sfr_rdata(sfr_rdata), .tbl(tbl), .tbl_ready(tbl_ready), .tbl_done(tbl_done), .flash_rd(flash_rd),
      .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .prog(prog), .cpu_stall(cpu_stall),
      .nvm_done_flag(nvm_done_flag), .nvm_done_clear(nvm_done_clear));
   flash_model far (.clk(clk), .nrst(nrst), .rd(flash_rd), .rdata(flash_rdata), .rvalid(flash_rvalid));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic final_report;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (e !== g) begin
         $display("mismatch %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   function automatic bit ok(input int w);
      case (w)
         0: return tbl_ready === 1'b1;
         1: return tbl_done === 1'b1;
         default: return prog.active === 1'b0;
      endcase
   endfunction
   task automatic wt(input int w, input int lim);
      int n;
      for (n = 0; n < lim && !ok(w); n++) @(negedge clk);
      if (n == lim) begin
         $display("mismatch wait %0d expected done seen timeout", w);
         miscompares++;
         final_report();
      end
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] v);
      // let one idle edge pass so a strobe is never lowered and raised in one step
      @(negedge clk);
      sfr = '{s, 1'b1, 1'b0, v};
      @(negedge clk);
      sfr = '0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [7:0] e);
      @(negedge clk);
      sfr = '{s, 1'b0, 1'b1, 8'h00};
      @(negedge clk);
      sfr = '0;
      chk($sformatf("reg%0d", s), e, sfr_rdata);
   endtask
   task automatic setptr(input logic [21:0] v);
      wr(SEL_PTR_UPPER, {2'b00, v[21:16]});
      wr(SEL_PTR_HIGH, v[15:8]);
      wr(SEL_PTR_LOW, v[7:0]);
      ptr = v;
   endtask
   task automatic top(input logic w, input tbl_mode_e md);
      wt(0, 20);
      tbl = '{1'b1, w, md};
      @(negedge clk);
      tbl = '0;
      wt(1, 20);
   endtask
   function automatic logic [21:0] step(input logic [21:0] v, input int s);
      return {v[21], 21'(v[20:0] + s)};
   endfunction
   task automatic go(input logic [7:0] c);
      wr(SEL_CONTROL, c);
      wr(SEL_UNLOCK, UNLOCK_KEY1);
      wr(SEL_UNLOCK, UNLOCK_KEY2);
      wr(SEL_CONTROL, c | 8'h02);
      @(negedge clk);
      chk("active", 1, {prog.active, cpu_stall} == 2'b11);
      chk("erase", c[4], prog.erase);
      chk("space", c[6] ? SPACE_CONFIG : c[7] ? SPACE_PROGRAM : SPACE_EEPROM, prog.space);
      chk("addr", c[4] ? {ptr[21:6], 6'h00} : {ptr[21:3], 3'h0}, prog.addr);
      chk("data", hold, prog.data);
      rd(SEL_CONTROL, c | 8'h0A);
      wt(2, PT + 10);
      chk("flag", 1, nvm_done_flag);
      chk("stall_end", 0, cpu_stall);
      rd(SEL_CONTROL, c & 8'hE4);
      nvm_done_clear = 1'b1;
      @(negedge clk);
      nvm_done_clear = 1'b0;
      chk("flag", 0, nvm_done_flag);
      hold = '1;
   endtask
   initial begin
      miscompares = 0;
      checks_done = 0;
      sfr = '0;
      tbl = '0;
      nvm_done_clear = 1'b0;
      hold = '1;
      nrst = 1'b0;
      void'($urandom(32'h6e28e1af));
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      for (int s = 0; s < 8; s++) rd(3'(s), 8'h00);
      wr(SEL_UNLOCK, UNLOCK_KEY1);
      rd(SEL_UNLOCK, 8'h00);
      for (int i = 0; i < 16; i++) begin
         p = (i == 0) ? 22'h3FFFFF : (i == 1) ? 22'h200000 : 22'($urandom);
         m = tbl_mode_e'((i < 2) ? i + 1 : $urandom_range(3));
         d = 8'($urandom);
         setptr(p);
         a = (m == TBL_PREINC) ? step(p, 1) : p;
         if (i % 2) begin
            wr(SEL_LATCH, d);
            top(1'b1, m);
            hold[8*a[2:0] +: 8] = d;
         end else begin
            top(1'b0, m);
            chk("rd_addr", a, flash_rd.addr);
            chk("rd_space", a[21] ? SPACE_CONFIG : SPACE_PROGRAM, flash_rd.space);
            rd(SEL_LATCH, a[0] ? a[15:8] ^ (a[21] ? 8'h02 : 8'h01) : a[7:0]);
         end
         ptr = (m == TBL_NONE) ? p : (m == TBL_POSTDEC) ? step(p, -1) : step(p, 1);
         rd(SEL_PTR_UPPER, {2'b00, ptr[21:16]});
         rd(SEL_PTR_HIGH, ptr[15:8]);
         rd(SEL_PTR_LOW, ptr[7:0]);
      end
      // control read start: config overrides program select, then program space
      for (int k = 0; k < 2; k++) begin
         wr(SEL_CONTROL, k ? 8'h80 : 8'hC0);
         wr(SEL_CONTROL, k ? 8'h81 : 8'hC1);
         wt(0, 20);
         chk("ctl_rd_space", k ? SPACE_PROGRAM : SPACE_CONFIG, flash_rd.space);
         chk("ctl_rd_addr", ptr, flash_rd.addr);
         rd(SEL_LATCH, ptr[0] ? ptr[15:8] ^ (k ? 8'h01 : 8'h02) : ptr[7:0]);
         rd(SEL_CONTROL, k ? 8'h80 : 8'hC0);
      end
      wr(SEL_CONTROL, 8'h84);
      wr(SEL_CONTROL, 8'h86);
      @(negedge clk);
      chk("no_start", 0, prog.active);
      rd(SEL_CONTROL, 8'h8C);
      go(8'h84);
      go(8'h94);
      go(8'h44);
      go(8'h04);
      final_report();
   end
endmodule // program_flash_table_access_bench
